// [common/dlseq_map.vh]
// Constants of the display list microsequencer
// Behaviour
// - Fetch address comes from refresh pointer
// - Move blanked, draw unblanked beam reposition
// - Latch data bus; decode register address
// - Opcode gives start; data to microcontroller
// - 512x40 store stepped by address counter
// - Register read data via output register
// - Instruction results drive graphic bus directly
// - Bits 0-16 code, A, B, carry
// - Branch target from bits 8-11, 19-22
// - Bit 17 low stalls while memory busy
// - Function strobes only when bit 18 low
// - Bit 24 low starts memory fetch
// - Direction low write, high read, fetch only
// - Sequence end loads next start address
// - Running bit low halted, forwarded out
// - Generator wait stalls while generator busy
// - Rotate moves text increment to Y
// - Empty glyph suppresses text increment move
// - Vector start with two info bits
// - Light pen enable and toggle branch tests
// - Three bits select branch; radar enable bit
// - 16-bit microcontroller makes fetch addresses
// - Branch code table 000 to 111
// - Counter advances every 300 ns unless waiting or halted
// - Conditional keeps top bit; absolute sets it
`ifndef DLSEQ_MAP_VH
`define DLSEQ_MAP_VH
// Control word field positions
`define CW_CODE_LO 0
`define CW_A_LO 8
`define CW_B_LO 12
`define CW_CARRY 16
`define CW_MEMWAIT 17
`define CW_FDEC 18
`define CW_EXT_LO 19
`define CW_FETCH 24
`define CW_DIR 25
`define CW_OUTLD 26
`define CW_PARSEL 27
`define CW_NEXT 28
`define CW_RUN 29
`define CW_GENWAIT 30
`define CW_RADAR 31
`define CW_VINFA 32
`define CW_VINFB 33
`define CW_ROT 34
`define CW_EMPTY 35
`define CW_VSTART 36
`define CW_BR_LO 37
// Branch test codes
`define BR_ABS 3'h0
`define BR_TOGGLE 3'h1
`define BR_UNUSED 3'h2
`define BR_PEN 3'h3
`define BR_ZERO 3'h4
`define BR_INDIR 3'h5
`define BR_RADAR 3'h6
`define BR_INHIBIT 3'h7
// Reset values and timing
`define STOP_ADDR 9'h000
`define STEP_NS 300
`define CLK_NS 5
`define STEP_CYCLES ((`STEP_NS + `CLK_NS - 1) / `CLK_NS)
// APB register offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_UADDR 12'h008
`define OFS_UDATA_LO 12'h00c
`define OFS_UDATA_HI 12'h010
`define OFS_OUTREG 12'h014
`endif

// [hdl/dlseq.v]
// Display list microsequencer: control store, branch logic, datapath, APB slave
`timescale 1ns/1ps
`default_nettype none
`include "dlseq_map.vh"
module dlseq
(
   input wire CORE_CLK,
   input wire RSTN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   input wire [15:0] PROC_DATA_IN,
   input wire PROC_DATA_STROBE,
   input wire [3:0] PROC_ADDR_IN,
   input wire PROC_REG_WRITE,
   input wire PROC_REG_STROBE,
   output reg [15:0] PROC_ADDR_LINES,
   output reg [15:0] PROC_DATA_LINES,
   output reg [15:0] GFX_DATA_LINES,
   output reg BUS_CYCLE_REQUEST,
   output reg BUS_WRITE,
   input wire MEM_BUSY,
   input wire GEN_BUSY,
   input wire EMPTY_GLYPH_N,
   input wire LIGHTPEN_DELAY_ENABLE,
   input wire RAMP_TOGGLE,
   input wire RADAR_REQUEST,
   output reg [15:0] FUNC_STROBES,
   output reg VECTOR_START,
   output reg VECTOR_INFO_A,
   output reg VECTOR_INFO_B,
   output reg BEAM_BLANK,
   output reg CONTROLLER_RUNNING,
   output reg PARAM_REG_SELECT,
   output reg [8:0] USTORE_ADDR
);
   // ----------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------
   reg [8:0] sync1_reg;
   reg [8:0] sync2_reg;
   wire [8:0] async_in = {RADAR_REQUEST, RAMP_TOGGLE, LIGHTPEN_DELAY_ENABLE, EMPTY_GLYPH_N,
      GEN_BUSY, MEM_BUSY, PROC_REG_STROBE, PROC_DATA_STROBE, PROC_REG_WRITE};
   // Two stages; only the second is read by logic
   always @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         sync1_reg <= 9'h000;
         sync2_reg <= 9'h000;
      end
      else
      begin
         sync1_reg <= async_in;
         sync2_reg <= sync1_reg;
      end
   end
   wire s_regwr = sync2_reg[0];
   wire s_dstb = sync2_reg[1];
   wire s_rstb = sync2_reg[2];
   wire s_mbusy = sync2_reg[3];
   wire s_gbusy = sync2_reg[4];
   wire s_empty_n = sync2_reg[5];
   wire s_pen = sync2_reg[6];
   wire s_tog = sync2_reg[7];
   wire s_radar = sync2_reg[8];
   // Bus words pass the same two stages, so they line up with their strobes
   reg [19:0] word1_reg;
   reg [19:0] word2_reg;
   always @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         word1_reg <= 20'h00000;
         word2_reg <= 20'h00000;
      end
      else
      begin
         word1_reg <= {PROC_ADDR_IN, PROC_DATA_IN};
         word2_reg <= word1_reg;
      end
   end
   wire [15:0] s_data = word2_reg[15:0];
   wire [3:0] s_addr = word2_reg[19:16];
   reg dstb_d_reg;
   reg rstb_d_reg;

   // ----------------------------------------------------------
   // Control store and decode tables
   // ----------------------------------------------------------
   reg [39:0] ustore [0:511];
   reg [7:0] opdecode [0:127];
   reg [7:0] regdecode [0:31];
   reg [39:0] cw;
   reg [8:0] uaddr_reg;
   reg [8:0] uaddr_next;
   reg [15:0] instr_reg;
   reg [15:0] operand_reg;
   reg [8:0] pending_start_reg;
   reg stop_req_reg;
   reg toggle_ff_reg;
   reg [15:0] regs [0:15];
   reg [15:0] alu_out;
   reg zero_reg;
   reg [7:0] step_cnt_reg;
   reg run_cmd_reg;
   reg [8:0] load_addr_reg;
   reg [39:0] load_data_reg;
   reg [15:0] outreg_reg;

   // Control word fields
   wire [7:0] f_code = cw[`CW_CODE_LO +: 8];
   wire [3:0] f_a = cw[`CW_A_LO +: 4];
   wire [3:0] f_b = cw[`CW_B_LO +: 4];
   wire f_carry = cw[`CW_CARRY];
   wire [4:0] f_ext = cw[`CW_EXT_LO +: 5];
   wire [2:0] f_br = cw[`CW_BR_LO +: 3];
   wire [8:0] br_target = {f_ext, f_a};

   // Stall conditions stretch the step by holding the counter
   wire stall = (!cw[`CW_MEMWAIT] && s_mbusy)
      || (!cw[`CW_GENWAIT] && s_gbusy);
   wire step_due = (step_cnt_reg == (`STEP_CYCLES - 1));
   // A cleared run bit lets the routine finish; its last step lands on the
   // stop address, so the controller never halts in mid-instruction
   wire seq_live = run_cmd_reg || (uaddr_reg != `STOP_ADDR);
   wire advance = step_due && !stall && seq_live;

   // Branch condition select
   reg br_take;
   always @*
   begin
      case (f_br)
         `BR_ABS: br_take = 1'b1;
         `BR_TOGGLE: br_take = toggle_ff_reg;
         `BR_UNUSED: br_take = 1'b0;
         `BR_PEN: br_take = s_pen;
         `BR_ZERO: br_take = zero_reg;
         `BR_INDIR: br_take = instr_reg[15];
         `BR_RADAR: br_take = s_radar && !cw[`CW_RADAR];
         default: br_take = 1'b0;
      endcase
   end

   // Address multiplexer: next instruction, branch or increment
   always @*
   begin
      uaddr_next = uaddr_reg;
      if (!cw[`CW_NEXT])
         uaddr_next = stop_req_reg ? `STOP_ADDR : pending_start_reg;
      else if (br_take && f_br == `BR_ABS)
         uaddr_next = {1'b1, br_target[7:0]};
      else if (br_take)
         uaddr_next = {uaddr_reg[8], br_target[7:0]};
      else
         uaddr_next = uaddr_reg + 9'h001;
   end

   // ----------------------------------------------------------
   // Datapath helpers
   // ----------------------------------------------------------
   // Sign extension mode applied to operand before ALU entry
   function [15:0] extend;
      input [15:0] d;
      input [4:0] m;
      begin
         extend = d;
         if (!m[3])
            extend = {d[7:0], d[15:8]};
         if (!m[0])
            extend = {{8{extend[7]}}, extend[7:0]};
         else if (!m[1])
            extend = {{10{extend[5]}}, extend[5:0]};
         else if (!m[2] || !m[4])
            extend = {{4{extend[11]}}, extend[11:0]};
      end
   endfunction

   // Reduced microcontroller: low code bits pick the operation
   reg [3:0] b_eff;
   reg [15:0] src;
   always @*
   begin
      b_eff = f_b;
      if (!cw[`CW_ROT])
         b_eff = {f_b[3:1], 1'b0};
      src = extend(operand_reg, f_ext);
      case (f_code[2:0])
         3'h0: alu_out = regs[f_a] + regs[b_eff] + {15'h0000, f_carry};
         3'h1: alu_out = regs[f_a] - regs[b_eff];
         3'h2: alu_out = src;
         3'h3: alu_out = (!cw[`CW_EMPTY] && !s_empty_n) ? regs[b_eff]
            : regs[b_eff] + src;
         3'h4: alu_out = regs[f_a] & regs[b_eff];
         3'h5: alu_out = regs[f_a] | regs[b_eff];
         3'h6: alu_out = regs[b_eff] + 16'h0002;
         default: alu_out = regs[b_eff];
      endcase
   end

   // ----------------------------------------------------------
   // Sequencer and datapath registers
   // ----------------------------------------------------------
   integer i;
   always @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         uaddr_reg <= `STOP_ADDR;
         cw <= 40'h0000000000;
         step_cnt_reg <= 8'h00;
         instr_reg <= 16'h0000;
         operand_reg <= 16'h0000;
         pending_start_reg <= `STOP_ADDR;
         stop_req_reg <= 1'b0;
         toggle_ff_reg <= 1'b0;
         zero_reg <= 1'b0;
         outreg_reg <= 16'h0000;
         dstb_d_reg <= 1'b0;
         rstb_d_reg <= 1'b0;
         for (i = 0; i < 16; i = i + 1)
            regs[i] <= 16'h0000;
      end
      else
      begin
         dstb_d_reg <= s_dstb;
         rstb_d_reg <= s_rstb;
         toggle_ff_reg <= s_tog;
         cw <= ustore[uaddr_reg];
         step_cnt_reg <= (step_due || !seq_live) ? 8'h00 : step_cnt_reg + 8'h01;
         if (s_dstb && !dstb_d_reg)
         begin
            instr_reg <= s_data;
            operand_reg <= {7'h00, s_data[8:0]};
            pending_start_reg <= {1'b0, opdecode[s_data[15:9]]};
         end
         if (s_rstb && !rstb_d_reg)
            pending_start_reg <= {1'b0, regdecode[{s_regwr, s_addr}]};
         stop_req_reg <= !run_cmd_reg;
         if (advance)
         begin
            uaddr_reg <= uaddr_next;
            regs[b_eff] <= alu_out;
            zero_reg <= (alu_out == 16'h0000);
            if (!cw[`CW_OUTLD])
               outreg_reg <= alu_out;
         end
      end
   end

   // Bus-facing outputs registered from the current step
   always @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         PROC_ADDR_LINES <= 16'h0000;
         PROC_DATA_LINES <= 16'h0000;
         GFX_DATA_LINES <= 16'h0000;
         BUS_CYCLE_REQUEST <= 1'b0;
         BUS_WRITE <= 1'b0;
         FUNC_STROBES <= 16'h0000;
         VECTOR_START <= 1'b0;
         VECTOR_INFO_A <= 1'b0;
         VECTOR_INFO_B <= 1'b0;
         BEAM_BLANK <= 1'b1;
         CONTROLLER_RUNNING <= 1'b0;
         PARAM_REG_SELECT <= 1'b0;
         USTORE_ADDR <= `STOP_ADDR;
      end
      else
      begin
         USTORE_ADDR <= uaddr_reg;
         PROC_ADDR_LINES <= regs[7];
         PROC_DATA_LINES <= outreg_reg;
         GFX_DATA_LINES <= alu_out;
         BUS_CYCLE_REQUEST <= advance && !cw[`CW_FETCH];
         BUS_WRITE <= advance && !cw[`CW_FETCH] && !cw[`CW_DIR];
         FUNC_STROBES <= (advance && !cw[`CW_FDEC]) ? (16'h0001 << f_b) : 16'h0000;
         VECTOR_START <= advance && !cw[`CW_VSTART]
            && !(!cw[`CW_EMPTY] && !s_empty_n);
         VECTOR_INFO_A <= cw[`CW_VINFA];
         VECTOR_INFO_B <= cw[`CW_VINFB];
         if (advance && !cw[`CW_VSTART])
            BEAM_BLANK <= !instr_reg[9];
         CONTROLLER_RUNNING <= cw[`CW_RUN] && run_cmd_reg;
         PARAM_REG_SELECT <= !cw[`CW_PARSEL];
      end
   end

   // ----------------------------------------------------------
   // APB slave: run control, store loading, status
   // ----------------------------------------------------------
   wire wr_en = PSEL && PENABLE && PWRITE;
   always @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         run_cmd_reg <= 1'b0;
         load_addr_reg <= 9'h000;
         load_data_reg <= 40'h0000000000;
      end
      else if (wr_en)
      begin
         case (PADDR)
            `OFS_CTRL: run_cmd_reg <= PWDATA[0];
            `OFS_UADDR: load_addr_reg <= PWDATA[8:0];
            `OFS_UDATA_LO: load_data_reg[31:0] <= PWDATA;
            default: load_data_reg <= load_data_reg;
         endcase
      end
   end

   // Writing the high word commits the staged store entry
   always @(posedge CORE_CLK)
   begin
      if (wr_en && PADDR == `OFS_UDATA_HI)
      begin
         if (PWDATA[31:30] == 2'h0)
            ustore[load_addr_reg] <= {PWDATA[7:0], load_data_reg[31:0]};
         else if (PWDATA[31:30] == 2'h1)
            opdecode[load_addr_reg[6:0]] <= PWDATA[7:0];
         else
            regdecode[load_addr_reg[4:0]] <= PWDATA[7:0];
      end
   end

   // Zero-wait read answer
   always @*
   begin
      case (PADDR)
         `OFS_CTRL: PRDATA = {31'h00000000, run_cmd_reg};
         `OFS_STATUS: PRDATA = {20'h00000, stall, CONTROLLER_RUNNING, zero_reg, uaddr_reg};
         `OFS_UADDR: PRDATA = {23'h000000, load_addr_reg};
         `OFS_OUTREG: PRDATA = {16'h0000, outreg_reg};
         default: PRDATA = 32'h00000000;
      endcase
   end
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !(PADDR == `OFS_CTRL || PADDR == `OFS_STATUS
      || PADDR == `OFS_UADDR || PADDR == `OFS_UDATA_LO || PADDR == `OFS_UDATA_HI
      || PADDR == `OFS_OUTREG);
endmodule
`default_nettype wire

// [tb/dlseq_assertions.sv]
// Port checker of the display list microsequencer
`timescale 1ns/1ps
`default_nettype none
`include "dlseq_map.vh"
module dlseq_assertions
(
   input wire CORE_CLK,
   input wire RSTN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire BUS_CYCLE_REQUEST,
   input wire BUS_WRITE,
   input wire [15:0] FUNC_STROBES,
   input wire VECTOR_START,
   input wire BEAM_BLANK,
   input wire CONTROLLER_RUNNING,
   input wire [8:0] USTORE_ADDR
);
   // ----
   // Properties
   // ----
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   // Access phases to places outside and inside the map
   sequence acc_bad;
      PSEL && PENABLE && PADDR > `OFS_OUTREG;
   endsequence
   sequence acc_ok;
      PSEL && PENABLE && PADDR <= `OFS_OUTREG && PADDR[1:0] == 2'h0;
   endsequence
   // Two reset edges, so the flops have had a clock to settle on
   sequence held_reset;
      !RSTN ##1 !RSTN;
   endsequence
   // Cycles since the counter last moved; a step needs the whole period
   int since_step;
   always @(posedge CORE_CLK)
   begin
      if (!RSTN)
         since_step <= 0;
      else if ($changed(USTORE_ADDR))
         since_step <= 0;
      else
         since_step <= since_step + 1;
   end
   a_ready_always: assert property (PSEL && PENABLE |-> PREADY)
      else $error("pready low in access");
   a_unmapped_err: assert property (acc_bad |-> PSLVERR)
      else $error("no error on unmapped access");
   a_mapped_ok: assert property (acc_ok |-> !PSLVERR)
      else $error("error on mapped access");
   a_unmapped_zero: assert property (acc_bad ##0 !PWRITE |-> PRDATA == 32'h0)
      else $error("unmapped read not zero");
   a_write_fetch: assert property (BUS_WRITE |-> BUS_CYCLE_REQUEST)
      else $error("write without fetch");
   a_fetch_pulse: assert property (BUS_CYCLE_REQUEST |=> !BUS_CYCLE_REQUEST)
      else $error("fetch request longer than a cycle");
   a_vstart_pulse: assert property (VECTOR_START |=> !VECTOR_START)
      else $error("vector start longer than a cycle");
   a_strobe_onehot: assert property ($onehot0(FUNC_STROBES))
      else $error("several function strobes");
   a_step_spacing: assert property ($changed(USTORE_ADDR) |=> $stable(USTORE_ADDR)[*8])
      else $error("counter stepped too soon");
   a_step_period: assert property ($changed(USTORE_ADDR) |-> since_step >= `STEP_CYCLES - 1)
      else $error("counter step shorter than period");
   a_reset_stop: assert property (disable iff (1'b0)
      held_reset |-> USTORE_ADDR == `STOP_ADDR && BEAM_BLANK && !CONTROLLER_RUNNING)
      else $error("reset state wrong");
endmodule
bind dlseq dlseq_assertions chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .BUS_CYCLE_REQUEST(BUS_CYCLE_REQUEST), .BUS_WRITE(BUS_WRITE),
   .FUNC_STROBES(FUNC_STROBES), .VECTOR_START(VECTOR_START), .BEAM_BLANK(BEAM_BLANK),
   .CONTROLLER_RUNNING(CONTROLLER_RUNNING), .USTORE_ADDR(USTORE_ADDR));
`default_nettype wire

// [tb/refresh_side.sv]
// Refresh memory and generator side of the processor bus
`timescale 1ns/1ps
`default_nettype none
module refresh_side
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hold_busy,
   input wire logic cycle_req,
   output logic mem_busy,
   output logic gen_busy,
   output logic [15:0] instr,
   output logic instr_stb
);
   logic [1:0] cnt_reg;
   // Every fetch keeps memory busy three cycles; hold_busy makes it slow
   always @(posedge clk or negedge rst_n)
      if (!rst_n) cnt_reg <= 2'h0;
      else if (cycle_req) cnt_reg <= 2'h3;
      else if (cnt_reg != 2'h0) cnt_reg <= cnt_reg - 2'h1;
   assign mem_busy = hold_busy || cnt_reg != 2'h0;
   // No processor commands issued, so the lines stay idle
   assign gen_busy = 1'b0;
   assign instr = 16'h0;
   assign instr_stb = 1'b0;
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the display list microsequencer
`timescale 1ns/1ps
`default_nettype none
`include "dlseq_map.vh"
module testbench;
   logic CORE_CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, hold = 0;
   logic glyph_n = 1, tog = 0;
   logic [11:0] PADDR = 0;
   logic [31:0] PWDATA = 0, rd;
   logic er, va;
   wire [31:0] PRDATA;
   wire [15:0] fs, ins;
   wire [8:0] ua;
   wire rdy, serr, req, bw, vs, via, bb, run, mb, gb, istb;
   int n_errors = 0, n_checks = 0, n_req = 0, n_wr = 0, n_vs = 0, n_fs = 0, n;
   always #2.5 CORE_CLK = ~CORE_CLK;
   dlseq uut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(rdy),
      .PSLVERR(serr), .PROC_DATA_IN(ins), .PROC_DATA_STROBE(istb), .PROC_ADDR_IN(4'h0),
      .PROC_REG_WRITE(1'b0), .PROC_REG_STROBE(1'b0), .PROC_ADDR_LINES(),
      .PROC_DATA_LINES(), .GFX_DATA_LINES(), .BUS_CYCLE_REQUEST(req), .BUS_WRITE(bw),
      .MEM_BUSY(mb), .GEN_BUSY(gb), .EMPTY_GLYPH_N(glyph_n), .LIGHTPEN_DELAY_ENABLE(1'b0),
      .RAMP_TOGGLE(tog), .RADAR_REQUEST(1'b0), .FUNC_STROBES(fs), .VECTOR_START(vs),
      .VECTOR_INFO_A(via), .VECTOR_INFO_B(), .BEAM_BLANK(bb), .CONTROLLER_RUNNING(run),
      .PARAM_REG_SELECT(), .USTORE_ADDR(ua));
   refresh_side mem (.clk(CORE_CLK), .rst_n(RSTN), .hold_busy(hold), .cycle_req(req),
      .mem_busy(mb), .gen_busy(gb), .instr(ins), .instr_stb(istb));
   // Pulse counters, since pulses stand only one cycle
   always @(posedge CORE_CLK)
   begin
      n_req += (req === 1'b1);
      n_wr += (bw === 1'b1);
      n_vs += (vs === 1'b1);
      n_fs += (fs !== 16'h0);
      if (vs === 1'b1) va = via;
   end
   // ----
   // Shared tasks
   // ----
   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // One APB transfer, held until pready at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      logic ok;
      @(posedge CORE_CLK);
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1;
      k = 0;
      // Answer read where it has settled, just before the edge that samples it
      do
      begin
         @(negedge CORE_CLK);
         ok = rdy;
         rd = PRDATA;
         er = serr;
         @(posedge CORE_CLK);
         k++;
      end
      while (ok !== 1'b1 && k < 50);
      PSEL <= 0;
      PENABLE <= 0;
      if (ok !== 1'b1)
      begin
         chk("pready", 1, ok);
         tally_and_finish();
      end
   endtask
   // A store word is written as address, low word, then committing high part
   task automatic sw(input logic [8:0] a, input logic [39:0] cw);
      apb(1, `OFS_UADDR, {23'h0, a});
      apb(1, `OFS_UDATA_LO, cw[31:0]);
      apb(1, `OFS_UDATA_HI, {24'h0, cw[39:32]});
   endtask
   task automatic wait_addr(input logic [8:0] t);
      n = 0;
      while (ua !== t && n < 2000)
      begin
         @(posedge CORE_CLK);
         #1;
         n++;
      end
      if (n >= 2000)
      begin
         chk("counter wait", t, ua);
         tally_and_finish();
      end
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_reset;
      chk("counter", `STOP_ADDR, ua);
      chk("blank", 1, bb);
      chk("running", 0, run);
      apb(1, 12'h020, 32'h1);
      chk("write err", 1, er);
      apb(0, 12'h020, 32'h0);
      chk("read err", 1, er);
      chk("read data", 0, rd);
      apb(0, `OFS_STATUS, 32'h0);
      chk("status", 0, rd[10:0]);
      $display("test reset done");
   endtask
   // Step 0x105 tests the toggle branch with an empty glyph; 0x10a ends the routine
   task automatic t_run;
      sw(9'h000, 40'hfc_fe06_0000);
      sw(9'h001, 40'hfc_fc04_0000);
      sw(9'h002, 40'h0d_ff06_0500);
      sw(9'h105, 40'h24_ff06_0a00);
      sw(9'h10a, 40'hfc_ef06_0000);
      apb(1, `OFS_CTRL, 32'h1);
      wait_addr(9'h001);
      hold <= 1;
      repeat (2) @(posedge CORE_CLK);
      chk("running", 1, run);
      chk("fetches", 1, n_req);
      chk("writes", 0, n_wr);
      repeat (200) @(posedge CORE_CLK);
      chk("stalled", 9'h001, ua);
      hold <= 0;
      wait_addr(9'h002);
      repeat (2) @(posedge CORE_CLK);
      chk("fetches", 2, n_req);
      chk("writes", 1, n_wr);
      wait_addr(9'h105);
      chk("step", `STEP_CYCLES, n + 2);
      repeat (2) @(posedge CORE_CLK);
      chk("vstart", 1, n_vs);
      chk("vinfo", 1, va);
      chk("blank move", 1, bb);
      chk("strobes", 0, n_fs);
      $display("test run done");
   endtask
   task automatic t_branch;
      glyph_n <= 0;
      tog <= 1;
      wait_addr(9'h10a);
      chk("step", `STEP_CYCLES, n + 2);
      repeat (2) @(posedge CORE_CLK);
      chk("vstart empty", 1, n_vs);
      wait_addr(`STOP_ADDR);
      chk("top bit", 0, ua[8]);
      $display("test branch done");
   endtask
   initial
   begin
      repeat (6) @(posedge CORE_CLK);
      RSTN <= 1;
      @(posedge CORE_CLK);
      t_reset();
      t_run();
      t_branch();
      tally_and_finish();
   end
endmodule
`default_nettype wire
